// ### core/pgr_pkg.sv
package pgr_pkg;

  // Register offsets on the serial management interface
  localparam logic [7:0] PGR_OFS_PIN_MASK = 8'hac;
  localparam logic [7:0] PGR_OFS_TERM_DIS = 8'had;
  localparam logic [7:0] PGR_OFS_AUX_CTRL = 8'hae;

  // Pin-mask field positions
  localparam int PGR_OUT1_IN3_BIT = 7;
  localparam int PGR_OUT1_IN6_BIT = 6;
  localparam int PGR_OUT4_IN3_BIT = 5;
  localparam int PGR_OUT4_IN6_BIT = 4;
  localparam int PGR_OUT2_IN3_BIT = 3;
  localparam int PGR_OUT2_IN6_BIT = 2;
  localparam int PGR_OUT3_IN3_BIT = 1;
  localparam int PGR_OUT3_IN6_BIT = 0;

  // Termination discharge field
  localparam int PGR_TERM_DIS_BIT = 4;

  // Auxiliary rail control fields
  localparam int PGR_AUX_DIS_HI = 7;
  localparam int PGR_AUX_DIS_LO = 6;
  localparam int PGR_AUX_SDWN_BIT = 5;
  localparam int PGR_AUX_VID_HI = 4;
  localparam int PGR_AUX_VID_LO = 1;
  localparam int PGR_AUX_EN_BIT = 0;

  // Discharge load selections
  typedef enum logic [1:0] {
    PGR_DIS_NONE = 2'h0,
    PGR_DIS_100 = 2'h1,
    PGR_DIS_200 = 2'h2,
    PGR_DIS_500 = 2'h3
  } pgr_dis_t;

  // Shutdown-off duration selections (factory programmed)
  localparam logic [1:0] PGR_SD_1MS = 2'h0;
  localparam logic [1:0] PGR_SD_5MS = 2'h1;
  localparam logic [1:0] PGR_SD_10MS = 2'h2;
  localparam logic [1:0] PGR_SD_100MS = 2'h3;

  // Timing: clock rate and shutdown durations in ms
  localparam int PGR_CLK_HZ = 200_000_000;
  localparam int PGR_TICK_CYCLES = PGR_CLK_HZ / 1000;
  localparam int PGR_SD_1MS_T = 1;
  localparam int PGR_SD_5MS_T = 5;
  localparam int PGR_SD_10MS_T = 10;
  localparam int PGR_SD_100MS_T = 100;

endpackage : pgr_pkg

// ### core/pgr_ms_tick.sv
// Millisecond enable pulse divided down from the system clock
module pgr_ms_tick #(
  parameter int TICK_CYCLES = pgr_pkg::PGR_TICK_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  output logic tick_out
);

  logic [17:0] cnt_q;

  // Free count while running, one-cycle pulse at wrap
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 18'h0_0000;
    end else if (!run_in) begin
      cnt_q <= 18'h0_0000;
    end else if (cnt_q == 18'(TICK_CYCLES - 1)) begin
      cnt_q <= 18'h0_0000;
    end else begin
      cnt_q <= cnt_q + 18'h0_0001;
    end
  end

  assign tick_out = run_in && (cnt_q == 18'(TICK_CYCLES - 1));

endmodule : pgr_ms_tick

// ### core/pgr_regs.sv
// Summary of operation
// - Pin-mask bits 7,6 drop input three/six from the first power-good.
// - Pin-mask bits 5,4 drop input three/six from the fourth power-good.
// - Pin-mask bits 3,2 drop input three/six from the second power-good.
// - Pin-mask bits 1,0 drop input three/six from the third power-good.
// - Termination discharge bit 4 selects none or a 100 ohm load.
// - Shutdown-config 0: rail turns off for factory time on shutdown.
// - Shutdown-config 1: rail ignores shutdown, follows enable only.
// - In sequence without merged switches, controls second load switch.
// - Aux bits 4:1 select the adjustable regulator output voltage code.
// - Aux bit 0 enables the controlled rail.
module pgr_regs (
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Register port of the serial management interface
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_hit_out,
  // Factory storage image, valid while otp_load_in is high
  input wire logic otp_load_in,
  input wire logic [7:0] otp_pin_mask_in,
  input wire logic [7:0] otp_term_dis_in,
  input wire logic [7:0] otp_aux_ctrl_in,
  input wire logic [1:0] otp_sd_time_in,
  input wire logic otp_aux_in_seq_in,
  input wire logic otp_switch_merge_in,
  // Power-good trees
  input wire logic [3:0] pg_tree_in,
  input wire logic control_input_three_in,
  input wire logic control_input_six_in,
  output logic pg_out_first_out,
  output logic pg_out_second_out,
  output logic pg_out_third_out,
  output logic pg_out_fourth_out,
  // Rails
  input wire logic emergency_shutdown_in,
  output logic term_discharge_sel_out,
  output logic [1:0] aux_discharge_sel_out,
  output logic [3:0] aux_voltage_code_out,
  output logic adj_reg_enable_out,
  output logic load_switch_second_enable_out,
  output logic aux_rail_off_busy_out
);

  logic [7:0] pin_mask_q;
  logic [7:0] term_dis_q;
  logic [7:0] aux_ctrl_q;
  logic [1:0] sd_time_q;
  logic to_switch_q;
  logic [6:0] sd_left_q;
  logic sd_busy_q;
  logic sd_prev_q;
  logic tick;
  logic rail_on;
  logic [3:0] pg_d;

  typedef enum logic [2:0] {
    PGR_ST_ON = 3'b001,
    PGR_ST_OFF = 3'b010,
    PGR_ST_HOLD = 3'b100
  } pgr_state_t;
  pgr_state_t st_q;

  // Contribution of one pin: a set mask bit removes it from the tree
  function automatic logic pin_ok(input logic pin, input logic msk);
    pin_ok = pin | msk;
  endfunction : pin_ok

  // Duration in ms for a factory time selection
  function automatic logic [6:0] sd_ms(input logic [1:0] sel);
    unique case (sel)
      pgr_pkg::PGR_SD_1MS: sd_ms = 7'(pgr_pkg::PGR_SD_1MS_T);
      pgr_pkg::PGR_SD_5MS: sd_ms = 7'(pgr_pkg::PGR_SD_5MS_T);
      pgr_pkg::PGR_SD_10MS: sd_ms = 7'(pgr_pkg::PGR_SD_10MS_T);
      default: sd_ms = 7'(pgr_pkg::PGR_SD_100MS_T);
    endcase
  endfunction : sd_ms

  // Registers: cleared under reset, then loaded from factory storage
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_mask_q <= 8'h00;
      term_dis_q <= 8'h00;
      aux_ctrl_q <= 8'h00;
    end else if (otp_load_in) begin
      pin_mask_q <= otp_pin_mask_in;
      term_dis_q <= otp_term_dis_in;
      aux_ctrl_q <= otp_aux_ctrl_in;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        pgr_pkg::PGR_OFS_PIN_MASK: pin_mask_q <= reg_wdata_in;
        // Reserved bits stored as written; software keeps them matching
        pgr_pkg::PGR_OFS_TERM_DIS: term_dis_q <= reg_wdata_in;
        pgr_pkg::PGR_OFS_AUX_CTRL: aux_ctrl_q <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Factory strap values caught while loading
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sd_time_q <= 2'h0;
      to_switch_q <= 1'b0;
    end else if (otp_load_in) begin
      sd_time_q <= otp_sd_time_in;
      to_switch_q <= otp_aux_in_seq_in & ~otp_switch_merge_in;
    end
  end

  // Read mux, unmapped offsets read zero with hit low
  always_comb begin
    reg_rdata_out = 8'h00;
    reg_hit_out = 1'b1;
    unique case (reg_addr_in)
      pgr_pkg::PGR_OFS_PIN_MASK: reg_rdata_out = pin_mask_q;
      pgr_pkg::PGR_OFS_TERM_DIS: reg_rdata_out = term_dis_q;
      pgr_pkg::PGR_OFS_AUX_CTRL: reg_rdata_out = aux_ctrl_q;
      default: reg_hit_out = 1'b0;
    endcase
    if (!reg_rd_in && !reg_wr_in) begin
      reg_hit_out = 1'b0;
    end
  end

  // Power-good trees with the two pins gated by their masks
  always_comb begin
    pg_d[0] = pg_tree_in[0]
      & pin_ok(control_input_three_in, pin_mask_q[pgr_pkg::PGR_OUT1_IN3_BIT])
      & pin_ok(control_input_six_in, pin_mask_q[pgr_pkg::PGR_OUT1_IN6_BIT]);
    pg_d[1] = pg_tree_in[1]
      & pin_ok(control_input_three_in, pin_mask_q[pgr_pkg::PGR_OUT2_IN3_BIT])
      & pin_ok(control_input_six_in, pin_mask_q[pgr_pkg::PGR_OUT2_IN6_BIT]);
    pg_d[2] = pg_tree_in[2]
      & pin_ok(control_input_three_in, pin_mask_q[pgr_pkg::PGR_OUT3_IN3_BIT])
      & pin_ok(control_input_six_in, pin_mask_q[pgr_pkg::PGR_OUT3_IN6_BIT]);
    pg_d[3] = pg_tree_in[3]
      & pin_ok(control_input_three_in, pin_mask_q[pgr_pkg::PGR_OUT4_IN3_BIT])
      & pin_ok(control_input_six_in, pin_mask_q[pgr_pkg::PGR_OUT4_IN6_BIT]);
  end

  // Power-good outputs, all four registered one cycle behind the trees
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pg_out_first_out <= 1'b0;
      pg_out_second_out <= 1'b0;
      pg_out_third_out <= 1'b0;
      pg_out_fourth_out <= 1'b0;
    end else begin
      pg_out_first_out <= pg_d[0];
      pg_out_second_out <= pg_d[1];
      pg_out_third_out <= pg_d[2];
      pg_out_fourth_out <= pg_d[3];
    end
  end

  pgr_ms_tick u_tick (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .run_in(sd_busy_q),
    .tick_out(tick)
  );

  // Emergency shutdown: rising edge starts a timed off period
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= PGR_ST_ON;
      sd_left_q <= 7'h00;
      sd_busy_q <= 1'b0;
      sd_prev_q <= 1'b0;
    end else begin
      sd_prev_q <= emergency_shutdown_in;
      unique case (st_q)
        PGR_ST_ON: begin
          if (emergency_shutdown_in && !sd_prev_q
              && !aux_ctrl_q[pgr_pkg::PGR_AUX_SDWN_BIT]) begin
            st_q <= PGR_ST_OFF;
            sd_left_q <= sd_ms(sd_time_q);
            sd_busy_q <= 1'b1;
          end
        end
        PGR_ST_OFF: begin
          if (tick) begin
            if (sd_left_q == 7'h01) begin
              st_q <= PGR_ST_HOLD;
              sd_busy_q <= 1'b0;
            end
            sd_left_q <= sd_left_q - 7'h01;
          end
        end
        PGR_ST_HOLD: begin
          // Wait for shutdown to drop before re-arming
          if (!emergency_shutdown_in) begin
            st_q <= PGR_ST_ON;
          end
        end
      endcase
    end
  end

  // Bypass mode follows enable alone; otherwise off while timing
  assign rail_on = aux_ctrl_q[pgr_pkg::PGR_AUX_EN_BIT]
    && (aux_ctrl_q[pgr_pkg::PGR_AUX_SDWN_BIT]
        || st_q != PGR_ST_OFF);

  // Rail and discharge outputs
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      term_discharge_sel_out <= 1'b0;
      aux_discharge_sel_out <= 2'h0;
      aux_voltage_code_out <= 4'h0;
      adj_reg_enable_out <= 1'b0;
      load_switch_second_enable_out <= 1'b0;
      aux_rail_off_busy_out <= 1'b0;
    end else begin
      term_discharge_sel_out <=
        term_dis_q[pgr_pkg::PGR_TERM_DIS_BIT];
      aux_discharge_sel_out <=
        aux_ctrl_q[pgr_pkg::PGR_AUX_DIS_HI:pgr_pkg::PGR_AUX_DIS_LO];
      aux_voltage_code_out <=
        aux_ctrl_q[pgr_pkg::PGR_AUX_VID_HI:pgr_pkg::PGR_AUX_VID_LO];
      adj_reg_enable_out <= rail_on && !to_switch_q;
      load_switch_second_enable_out <= rail_on && to_switch_q;
      aux_rail_off_busy_out <= (st_q == PGR_ST_OFF);
    end
  end

endmodule : pgr_regs

// ### tb/pgr_regs_asserts.sv
module pgr_regs_asserts (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_hit_out,
  input wire logic otp_load_in,
  input wire logic [3:0] pg_tree_in,
  input wire logic pg_out_first_out,
  input wire logic pg_out_second_out,
  input wire logic pg_out_third_out,
  input wire logic pg_out_fourth_out,
  input wire logic emergency_shutdown_in,
  input wire logic term_discharge_sel_out,
  input wire logic [1:0] aux_discharge_sel_out,
  input wire logic [3:0] aux_voltage_code_out,
  input wire logic adj_reg_enable_out,
  input wire logic load_switch_second_enable_out,
  input wire logic aux_rail_off_busy_out
);
  // Address decode, and quiet follow-up cycles for the aux and termination registers
  wire logic to_ae = reg_addr_in == pgr_pkg::PGR_OFS_AUX_CTRL;
  wire logic to_ad = reg_addr_in == pgr_pkg::PGR_OFS_TERM_DIS;
  wire logic to_ac = reg_addr_in == pgr_pkg::PGR_OFS_PIN_MASK;
  wire logic wr_ok = reg_wr_in && !otp_load_in;
  wire logic quiet_ae = !otp_load_in && !(reg_wr_in && to_ae);
  wire logic quiet_ad = !otp_load_in && !(reg_wr_in && to_ad);
  wire logic rail_on = adj_reg_enable_out || load_switch_second_enable_out;
  wire logic [3:0] pg_all = {pg_out_fourth_out, pg_out_third_out,
    pg_out_second_out, pg_out_first_out};

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // Written values reach read data and the rail controls
  read_back_a: assert property (wr_ok && to_ae ##1 reg_rd_in && to_ae
    |-> reg_rdata_out == $past(reg_wdata_in)) else $error("read back");
  vcode_follow_a: assert property (wr_ok && to_ae ##1 quiet_ae |=>
    aux_voltage_code_out == $past(reg_wdata_in[4:1], 2)) else $error("vcode");
  aux_dis_follow_a: assert property (wr_ok && to_ae ##1 quiet_ae |=>
    aux_discharge_sel_out == $past(reg_wdata_in[7:6], 2)) else $error("adis");
  term_dis_follow_a: assert property (wr_ok && to_ad ##1 quiet_ad |=>
    term_discharge_sel_out == $past(reg_wdata_in[4], 2)) else $error("tdis");
  bypass_enable_a: assert property (wr_ok && to_ae && reg_wdata_in[5]
    ##1 quiet_ae |=> rail_on == $past(reg_wdata_in[0], 2)) else $error("en");
  hit_decode_a: assert property (reg_rd_in || reg_wr_in |->
    reg_hit_out == (to_ae || to_ad || to_ac)) else $error("hit");
  // Off period starts only from a shutdown and with the rail off
  off_start_a: assert property ($rose(aux_rail_off_busy_out) |->
    $past(emergency_shutdown_in, 2) && !rail_on) else $error("off");
  // A bad tree contributor can never show as good
  pg_gate_a: assert property ((pg_all & ~$past(pg_tree_in)) == 4'h0)
    else $error("pg");

  cover property (wr_ok && to_ae ##1 quiet_ae ##1 rail_on);
  cover property ($rose(aux_rail_off_busy_out));
  cover property (pg_all == 4'hf);
endmodule : pgr_regs_asserts

bind pgr_regs pgr_regs_asserts u_chk (
  .clock_in(clock_in),
  .rst_n_in(rst_n_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out),
  .reg_hit_out(reg_hit_out),
  .otp_load_in(otp_load_in),
  .pg_tree_in(pg_tree_in),
  .pg_out_first_out(pg_out_first_out),
  .pg_out_second_out(pg_out_second_out),
  .pg_out_third_out(pg_out_third_out),
  .pg_out_fourth_out(pg_out_fourth_out),
  .emergency_shutdown_in(emergency_shutdown_in),
  .term_discharge_sel_out(term_discharge_sel_out),
  .aux_discharge_sel_out(aux_discharge_sel_out),
  .aux_voltage_code_out(aux_voltage_code_out),
  .adj_reg_enable_out(adj_reg_enable_out),
  .load_switch_second_enable_out(load_switch_second_enable_out),
  .aux_rail_off_busy_out(aux_rail_off_busy_out)
);

// ### tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic otp_load_in = 1'b0, otp_aux_in_seq_in = 1'b0;
  logic otp_switch_merge_in = 1'b0;
  logic [7:0] otp_pin_mask_in = 8'h5a, otp_term_dis_in = 8'h5f;
  logic [7:0] otp_aux_ctrl_in = 8'h6b;
  logic [1:0] otp_sd_time_in = 2'h0;
  logic [3:0] pg_tree_in = 4'h0;
  logic control_input_three_in = 1'b0, control_input_six_in = 1'b0;
  logic emergency_shutdown_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic reg_hit_out, pg_out_first_out, pg_out_second_out, pg_out_third_out;
  logic pg_out_fourth_out, term_discharge_sel_out, adj_reg_enable_out;
  logic load_switch_second_enable_out, aux_rail_off_busy_out;
  logic [1:0] aux_discharge_sel_out;
  logic [3:0] aux_voltage_code_out;
  int miscompares = 0, comparisons = 0, cycles = 0;
  // Rows: mask, {0,0,pin3,pin6}, tree, expected {fourth,third,second,first}
  logic [19:0] rows [15] = '{20'h0_03ff, 20'h0_01f0, 20'ha_a1ff, 20'h5_52ff,
    20'h8_01f1, 20'h4_02f1, 20'h2_01f8, 20'h1_02f8, 20'h0_81f2, 20'h0_42f2,
    20'h0_21f4, 20'h0_12f4, 20'hf_f055, 20'hf_f0aa, 20'h0_0300};

  pgr_regs uut (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .reg_hit_out(reg_hit_out),
    .otp_load_in(otp_load_in),
    .otp_pin_mask_in(otp_pin_mask_in),
    .otp_term_dis_in(otp_term_dis_in),
    .otp_aux_ctrl_in(otp_aux_ctrl_in),
    .otp_sd_time_in(otp_sd_time_in),
    .otp_aux_in_seq_in(otp_aux_in_seq_in),
    .otp_switch_merge_in(otp_switch_merge_in),
    .pg_tree_in(pg_tree_in),
    .control_input_three_in(control_input_three_in),
    .control_input_six_in(control_input_six_in),
    .pg_out_first_out(pg_out_first_out),
    .pg_out_second_out(pg_out_second_out),
    .pg_out_third_out(pg_out_third_out),
    .pg_out_fourth_out(pg_out_fourth_out),
    .emergency_shutdown_in(emergency_shutdown_in),
    .term_discharge_sel_out(term_discharge_sel_out),
    .aux_discharge_sel_out(aux_discharge_sel_out),
    .aux_voltage_code_out(aux_voltage_code_out),
    .adj_reg_enable_out(adj_reg_enable_out),
    .load_switch_second_enable_out(load_switch_second_enable_out),
    .aux_rail_off_busy_out(aux_rail_off_busy_out)
  );

  initial begin
    forever #2.5 clock_in = ~clock_in;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge clock_in);
    reg_wr_in = 1'b0;
  endtask : wr

  // Read compares hit flag and data; only the three offsets answer
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    #1 chk({reg_hit_out, reg_rdata_out}, {a >= 8'hac && a <= 8'hae, d});
    @(negedge clock_in);
    reg_rd_in = 1'b0;
    // Idle cycle so a following read does not re-raise the strobe at once
    @(negedge clock_in);
  endtask : rd

  task automatic load(input logic seq);
    otp_aux_in_seq_in = seq;
    otp_load_in = 1'b1;
    @(negedge clock_in);
    otp_load_in = 1'b0;
    repeat (2) @(negedge clock_in);
  endtask : load

  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // Hang guard
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      test_done;
    end
  end

  initial begin
    logic [7:0] d;
    repeat (20) @(negedge clock_in);
    rst_n_in = 1'b1;
    @(negedge clock_in);
    chk({adj_reg_enable_out, term_discharge_sel_out}, 16'h0000);
    load(1'b0);
    rd(8'hac, 8'h5a);
    rd(8'had, 8'h5f);
    rd(8'hae, 8'h6b);
    chk({term_discharge_sel_out, aux_discharge_sel_out}, 3'h5);
    chk(aux_voltage_code_out, 4'h5);
    chk({adj_reg_enable_out, load_switch_second_enable_out},
      16'h0002);
    $display("factory load test done");
    foreach (rows[i]) begin
      wr(8'hac, rows[i][19:12]);
      {control_input_three_in, control_input_six_in} = rows[i][9:8];
      pg_tree_in = rows[i][7:4];
      repeat (2) @(negedge clock_in);
      chk({pg_out_fourth_out, pg_out_third_out, pg_out_second_out,
        pg_out_first_out}, rows[i][3:0]);
      rd(8'hac, rows[i][19:12]);
    end
    $display("power-good mask test done");
    for (int i = 0; i < 4; i++) begin
      d = {2'(i), 1'b1, 4'(i * 3), 1'b1};
      wr(8'hae, d);
      @(negedge clock_in);
      chk({aux_discharge_sel_out, aux_voltage_code_out},
        {d[7:6], d[4:1]});
      rd(8'hae, d);
    end
    wr(8'had, 8'h4f);
    @(negedge clock_in);
    chk(term_discharge_sel_out, 16'h0000);
    wr(8'haf, 8'hff);
    rd(8'haf, 8'h00);
    rd(8'hae, d);
    $display("register access test done");
    wr(8'hae, 8'h21);
    // Read straight after the write to see the new value at once
    rd(8'hae, 8'h21);
    emergency_shutdown_in = 1'b1;
    repeat (5) @(negedge clock_in);
    chk({adj_reg_enable_out, aux_rail_off_busy_out}, 16'h0002);
    emergency_shutdown_in = 1'b0;
    wr(8'hae, 8'h00);
    @(negedge clock_in);
    wr(8'hae, 8'h01);
    repeat (2) @(negedge clock_in);
    chk(adj_reg_enable_out, 16'h0001);
    emergency_shutdown_in = 1'b1;
    repeat (4) @(negedge clock_in);
    chk({adj_reg_enable_out, aux_rail_off_busy_out}, 16'h0001);
    emergency_shutdown_in = 1'b0;
    rst_n_in = 1'b0;
    @(negedge clock_in);
    chk({adj_reg_enable_out, aux_rail_off_busy_out}, 16'h0000);
    rst_n_in = 1'b1;
    load(1'b1);
    chk({adj_reg_enable_out, load_switch_second_enable_out},
      16'h0001);
    // Merged switches leave the enable on the regulator
    otp_switch_merge_in = 1'b1;
    load(1'b1);
    chk({adj_reg_enable_out, load_switch_second_enable_out},
      16'h0002);
    $display("rail control test done");
    test_done;
  end
endmodule : tb_top
